// ==== design/ccms_cpu_clock_mode_select.v ====
// CPU clock mode select: strap capture, clock source choice and oscillator watchdog
// Overview of operation
// - Capture the three clock-mode straps during reset; they choose the clock path.
// - Decode 111 x4, 110 x3, 101 x8, 100 x5, 011 x1, 010 x10, 001 /2, 000 x16.
// - Strap 001 gives CPU clock as oscillator clock divided by two.
// - In prescaler mode each CPU clock phase lasts one crystal period.
// - Strap 011 bypasses amplifier, drives CPU clock from crystal pin; PLL is off only with watchdog disabled.
// - Direct drive keeps the incoming duty cycle, no correction.
// - Prescaler or direct: watchdog enabled runs PLL free; disabled powers PLL off.
// - Both CPU clock edges are timing units, each half-period one unit.
// - In direct drive two consecutive half-periods equal one input period.
// - Watchdog is enabled after reset; disable bit is configuration bit 4.
// - Watchdog counter counts PLL free clocks, clears on every crystal transition.
// - Overflow after 16 PLL clocks switches CPU clock to PLL free clock, flags request.
// - After fallback, CPU clock stays on PLL free clock until next reset.
`include "ccms_defs.vh"
`default_nettype none

module ccms_cpu_clock_mode_select (
   input  wire        mclk,
   input  wire        resetn,
   input  wire [2:0]  clock_mode_straps,
   input  wire        crystal_input_pin,
   input  wire        pll_mult_clock,
   input  wire        pll_free_clock,
   input  wire [7:0]  system_config_reg,
   output reg         cpu_clock,
   output reg         half_clock_period,
   output reg  [2:0]  clock_mode,
   output reg  [4:0]  pll_factor,
   output reg         pll_enable,
   output reg         pll_free_run,
   output reg         osc_amp_bypass,
   output reg         osc_watchdog_fallback,
   output reg         osc_watchdog_irq
);

   reg        xtal_s1_q;
   reg        xtal_s2_q;
   reg        xtal_s3_q;
   reg  [2:0] mode_q;
   reg  [4:0] owd_cnt_q;
   reg  [4:0] owd_cnt_d;
   reg        fallback_q;
   reg        irq_q;
   reg        pll_free_prev_q;
   reg        presc_q;
   reg        cpu_clk_q;
   reg        cpu_clk_d;
   reg  [1:0] src;
   wire       xtal_edge;
   wire       xtal_rise;
   wire       pll_free_rise;
   wire       slow_mode;
   wire       owd_disable;
   wire       owd_active;
   wire       owd_overflow;

   // Strap value to multiplication factor
   function [4:0] ccms_factor;
      input [2:0] mode;
      begin
         case (mode)
            `CCMS_MODE_X4:       ccms_factor = `CCMS_FACTOR_4;
            `CCMS_MODE_X3:       ccms_factor = `CCMS_FACTOR_3;
            `CCMS_MODE_X8:       ccms_factor = `CCMS_FACTOR_8;
            `CCMS_MODE_X5:       ccms_factor = `CCMS_FACTOR_5;
            `CCMS_MODE_DIRECT:   ccms_factor = `CCMS_FACTOR_1;
            `CCMS_MODE_X10:      ccms_factor = `CCMS_FACTOR_10;
            `CCMS_MODE_PRESCALE: ccms_factor = `CCMS_FACTOR_1;
            `CCMS_MODE_X16:      ccms_factor = `CCMS_FACTOR_16;
            default:             ccms_factor = `CCMS_FACTOR_4;
         endcase
      end
   endfunction

   // Direct drive decode, shared by source choice and amplifier bypass
   function ccms_is_direct;
      input [2:0] mode;
      begin
         ccms_is_direct = (mode == `CCMS_MODE_DIRECT);
      end
   endfunction

   // Prescaler decode, shared by source choice and watchdog gating
   function ccms_is_presc;
      input [2:0] mode;
      begin
         ccms_is_presc = (mode == `CCMS_MODE_PRESCALE);
      end
   endfunction

   // Crystal pin is asynchronous: two stages, then a third for edge detection
   // No reset here, so a crystal standing high at release gives no false edge
   always @(posedge mclk) begin
      xtal_s1_q <= crystal_input_pin;
      xtal_s2_q <= xtal_s1_q;
      xtal_s3_q <= xtal_s2_q;
   end

   // Straps sampled only while reset is low; the synchroniser keeps running through
   // reset via a separate flop pair so the captured value is settled at release
   reg [2:0] rst_strap_s1_q;
   reg [2:0] rst_strap_s2_q;
   always @(posedge mclk) begin
      rst_strap_s1_q <= clock_mode_straps;
      rst_strap_s2_q <= rst_strap_s1_q;
      if (!resetn) begin
         mode_q <= rst_strap_s2_q;
      end
   end

   assign xtal_edge     = xtal_s2_q ^ xtal_s3_q;
   assign xtal_rise     = xtal_s2_q & ~xtal_s3_q;
   assign pll_free_rise = pll_free_clock & ~pll_free_prev_q;
   // Watchdog only matters while the crystal itself drives the CPU clock
   assign slow_mode     = ccms_is_direct(mode_q) || ccms_is_presc(mode_q);
   assign owd_disable   = system_config_reg[`CCMS_OWD_DIS_BIT];
   assign owd_active    = slow_mode && !owd_disable;
   // Next count is compared, so the flags rise with the sixteenth edge
   assign owd_overflow  = owd_active && !fallback_q && (owd_cnt_d == `CCMS_OWD_OVERFLOW);

   // Watchdog counter: any crystal edge clears it, so only a stalled
   // crystal lets it climb to the overflow value
   always @* begin
      owd_cnt_d = owd_cnt_q;
      if (!owd_active || fallback_q || xtal_edge) begin
         owd_cnt_d = `CCMS_OWD_CNT_ZERO;
      end else if (pll_free_rise) begin
         owd_cnt_d = owd_cnt_q + `CCMS_OWD_CNT_ONE;
      end
   end

   // Clock source and next CPU clock level
   // Fallback outranks the straps, so a dead crystal cannot stall the CPU
   always @* begin
      if (fallback_q) begin
         src = `CCMS_SRC_PLL_FREE;
      end else if (ccms_is_presc(mode_q)) begin
         src = `CCMS_SRC_PRESCALE;
      end else if (ccms_is_direct(mode_q)) begin
         src = `CCMS_SRC_DIRECT;
      end else begin
         src = `CCMS_SRC_PLL_MULT;
      end
      case (src)
         `CCMS_SRC_PRESCALE: cpu_clk_d = presc_q;
         `CCMS_SRC_DIRECT:   cpu_clk_d = xtal_s2_q;
         `CCMS_SRC_PLL_FREE: cpu_clk_d = pll_free_clock;
         default:            cpu_clk_d = pll_mult_clock;
      endcase
   end

   // Watchdog counter and free clock edge state
   always @(posedge mclk) begin
      if (!resetn) begin
         owd_cnt_q       <= `CCMS_OWD_CNT_ZERO;
         pll_free_prev_q <= 1'h0;
      end else begin
         pll_free_prev_q <= pll_free_clock;
         owd_cnt_q       <= owd_cnt_d;
      end
   end

   // Fallback is sticky: only reset returns the CPU clock to the crystal
   always @(posedge mclk) begin
      if (!resetn) begin
         fallback_q <= 1'h0;
         irq_q      <= 1'h0;
      end else if (owd_overflow) begin
         fallback_q <= 1'h1;
         irq_q      <= 1'h1;
      end
   end

   // Toggle once per crystal period: each phase is one full input period
   always @(posedge mclk) begin
      if (!resetn) begin
         presc_q <= 1'h0;
      end else if (xtal_rise) begin
         presc_q <= ~presc_q;
      end
   end

   // One extra stage keeps the source mux glitches off cpu_clock
   always @(posedge mclk) begin
      if (!resetn) begin
         cpu_clk_q <= 1'h0;
      end else begin
         cpu_clk_q <= cpu_clk_d;
      end
   end

   // Registered outputs, one edge behind the internal state
   always @(posedge mclk) begin
      if (!resetn) begin
         cpu_clock             <= 1'h0;
         half_clock_period     <= 1'h0;
         clock_mode            <= `CCMS_MODE_RESET;
         pll_factor            <= `CCMS_FACTOR_4;
         pll_enable            <= 1'h0;
         pll_free_run          <= 1'h0;
         osc_amp_bypass        <= 1'h0;
         osc_watchdog_fallback <= 1'h0;
         osc_watchdog_irq      <= 1'h0;
      end else begin
         cpu_clock             <= cpu_clk_q;
         half_clock_period     <= cpu_clk_q ^ cpu_clock;
         clock_mode            <= mode_q;
         pll_factor            <= ccms_factor(mode_q);
         pll_enable            <= !slow_mode || owd_active;
         pll_free_run          <= owd_active;
         osc_amp_bypass        <= ccms_is_direct(mode_q);
         osc_watchdog_fallback <= fallback_q;
         osc_watchdog_irq      <= irq_q;
      end
   end

endmodule // ccms_cpu_clock_mode_select

`default_nettype wire

// ==== design/ccms_defs.vh ====
// Constants for the CPU clock mode select block
`ifndef CCMS_DEFS_VH
`define CCMS_DEFS_VH

`define CCMS_MODE_W          3
`define CCMS_MODE_X4         3'h7
`define CCMS_MODE_X3         3'h6
`define CCMS_MODE_X8         3'h5
`define CCMS_MODE_X5         3'h4
`define CCMS_MODE_DIRECT     3'h3
`define CCMS_MODE_X10        3'h2
`define CCMS_MODE_PRESCALE   3'h1
`define CCMS_MODE_X16        3'h0
`define CCMS_MODE_RESET      3'h7

`define CCMS_FACTOR_W        5
`define CCMS_FACTOR_4        5'h04
`define CCMS_FACTOR_3        5'h03
`define CCMS_FACTOR_8        5'h08
`define CCMS_FACTOR_5        5'h05
`define CCMS_FACTOR_1        5'h01
`define CCMS_FACTOR_10       5'h0A
`define CCMS_FACTOR_16       5'h10

`define CCMS_OWD_DIS_BIT     4
`define CCMS_OWD_CNT_W       5
`define CCMS_OWD_OVERFLOW    5'h10
`define CCMS_OWD_CNT_ZERO    5'h00
`define CCMS_OWD_CNT_ONE     5'h01

`define CCMS_SRC_PLL_MULT    2'h0
`define CCMS_SRC_PRESCALE    2'h1
`define CCMS_SRC_DIRECT      2'h2
`define CCMS_SRC_PLL_FREE    2'h3

`endif

// ==== sim/ccms_chk.sv ====
// Assertions on the clock mode select ports
`default_nettype none
module ccms_chk (
   input wire logic       mclk,
   input wire logic       resetn,
   input wire logic       crystal_input_pin,
   input wire logic       pll_mult_clock,
   input wire logic [7:0] system_config_reg,
   input wire logic       cpu_clock,
   input wire logic       half_clock_period,
   input wire logic [2:0] clock_mode,
   input wire logic [4:0] pll_factor,
   input wire logic       pll_enable,
   input wire logic       pll_free_run,
   input wire logic       osc_amp_bypass,
   input wire logic       osc_watchdog_fallback,
   input wire logic       osc_watchdog_irq
);
   timeunit 1ns;
   timeprecision 1ns;
   wire dm = clock_mode == 3'h1 || clock_mode == 3'h3;
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   function automatic logic [4:0] fx(input logic [2:0] m);
      case (m)
         3'h0: fx = 5'h10;
         3'h2: fx = 5'h0A;
         3'h4: fx = 5'h05;
         3'h5: fx = 5'h08;
         3'h6: fx = 5'h03;
         3'h7: fx = 5'h04;
         default: fx = 5'h01;
      endcase
   endfunction
   // Two edges after release, since capture lands on the first
   mode_hold_a: assert property ($past(resetn, 2) |-> $stable(clock_mode)) else $error("mode moved");
   factor_map_a: assert property ($past(resetn, 2) |-> pll_factor == fx(clock_mode)) else $error("factor");
   amp_bypass_a: assert property ($past(resetn, 2) |-> osc_amp_bypass == (clock_mode == 3'h3)) else $error("bypass");
   pll_power_a: assert property ($past(resetn, 2) |-> pll_enable == (!dm || !system_config_reg[4])) else $error("pll on");
   free_run_a: assert property ($past(resetn, 2) |-> pll_free_run == (dm && !system_config_reg[4])) else $error("free");
   flag_pair_a: assert property (osc_watchdog_fallback == osc_watchdog_irq) else $error("flag pair");
   fallback_hold_a: assert property (osc_watchdog_fallback |=> osc_watchdog_fallback) else $error("fallback lost");
   half_unit_a: assert property ($changed(cpu_clock) |-> ##[0:1] half_clock_period) else $error("half");
   half_edge_a: assert property (half_clock_period |-> $changed(cpu_clock)) else $error("half stray");
   // Watchdog off only, so no fallback can steal the path
   direct_follow_a: assert property (clock_mode == 3'h3 && system_config_reg[4] && $past(resetn, 6) |->
      cpu_clock == $past(crystal_input_pin, 3) || cpu_clock == $past(crystal_input_pin, 4)) else $error("direct");
   mult_follow_a: assert property (!dm && $past(resetn, 4) |-> cpu_clock == $past(pll_mult_clock, 2)) else $error("mult");
   cover property ($rose(osc_watchdog_fallback));
   cover property (clock_mode == 3'h1 && $changed(cpu_clock));
   cover property (clock_mode == 3'h3 && $changed(cpu_clock));
endmodule // ccms_chk
bind ccms_cpu_clock_mode_select ccms_chk ccms_chk_inst (.*);
`default_nettype wire

// ==== sim/ccms_xtal_model.sv ====
// Board side: crystal with uneven duty and the two PLL clocks
`default_nettype none
module ccms_xtal_model (
   input  wire logic mclk,
   input  wire logic run,
   output var  logic xtal,
   output var  logic pmul,
   output var  logic pfree
);
   timeunit 1ns;
   timeprecision 1ns;
   int n = 0;
   initial begin
      xtal = 0;
      pmul = 0;
      pfree = 0;
   end
   // Crystal 5 high, 11 low; a stopped crystal stands still
   always @(negedge mclk) begin
      n <= (n + 1) % 48;
      if (run)
         xtal <= (n % 16) < 5;
      pmul <= n[1];
      pfree <= (n % 6) < 3;
   end
endmodule // ccms_xtal_model
`default_nettype wire

// ==== sim/ccms_tb_top.sv ====
// Self-checking bench for the clock mode select block
`default_nettype none
module cpu_clock_mode_select_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 0, resetn = 0, run = 1;
   logic [2:0] straps = 3'h7;
   logic [7:0] cfg = 8'h00;
   wire logic xtal, pmul, pfree, cpu, half, en, fr, byp, fb, irq;
   wire logic [2:0] mode;
   wire logic [4:0] fac;
   int n_fail = 0, compares = 0, seed = 94, hi, lo;
   int ftab[8] = '{16, 1, 10, 1, 5, 8, 3, 4};
   always #5 mclk = ~mclk;
   ccms_xtal_model ccms_xtal_model_inst (.mclk(mclk), .run(run), .xtal(xtal), .pmul(pmul), .pfree(pfree));
   ccms_cpu_clock_mode_select ccms_cpu_clock_mode_select_inst (.mclk(mclk), .resetn(resetn),
      .clock_mode_straps(straps), .crystal_input_pin(xtal), .pll_mult_clock(pmul), .pll_free_clock(pfree),
      .system_config_reg(cfg), .cpu_clock(cpu), .half_clock_period(half), .clock_mode(mode), .pll_factor(fac),
      .pll_enable(en), .pll_free_run(fr), .osc_amp_bypass(byp), .osc_watchdog_fallback(fb), .osc_watchdog_irq(irq));
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %0d seen %0d", nm, exp, seen);
      end
   endtask
   task automatic finish_test;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Cycles until cpu_clock next changes, bounded
   task automatic phase(output int c);
      logic v;
      v = cpu;
      c = 0;
      while (cpu === v && c < 99) begin
         @(negedge mclk);
         c++;
      end
      chk("phase_edge", c < 99, 1);
      chk("half", half, 1);
   endtask
   initial begin : main
      int m, p, dm, ef;
      for (p = 0; p < 2; p++)
         for (m = 0; m < 8; m++) begin
            dm = m == 1 || m == 3;
            cfg = 8'($random(seed));
            if (dm) cfg[4] = p[0];
            ef = dm && !cfg[4];
            straps = m[2:0];
            run = 1;
            resetn = 0;
            repeat (20) @(negedge mclk);
            resetn = 1;
            straps = 3'($random(seed));
            repeat (40) @(negedge mclk);
            chk("mode", mode, m);
            chk("factor", fac, ftab[m]);
            chk("bypass", byp, m == 3);
            chk("pll_on", en, !dm || cfg[4] == 0);
            chk("free_run", fr, ef);
            chk("fallback", fb, 0);
            phase(hi);
            phase(hi);
            phase(lo);
            if (m == 1) chk("presc", hi + lo, 32);
            if (m == 3) chk("pair", hi + lo, 16);
            if (m == 3) chk("duty", hi * lo, 55);
            if (!dm) chk("mult", hi + lo, 4);
            run = 0;
            repeat (150) @(negedge mclk);
            chk("irq", irq, ef);
            run = 1;
            repeat (60) @(negedge mclk);
            chk("held", fb, ef);
            phase(hi);
            phase(hi);
            if (ef) chk("free", hi, 3);
            $display("test mode %0d pass %0d done", m, p);
         end
      finish_test;
   end
   // Runs take about 4700 cycles; far beyond that is a hang
   initial begin
      #400000;
      n_fail++;
      finish_test;
   end
endmodule // cpu_clock_mode_select_tb_top
`default_nettype wire
